// *** hw/sipc_pin_drive.sv ***
`default_nettype none

// ==========================================================================
// Registered driver for one interrupt pin: polarity and drive mode.
// ==========================================================================
module sipc_pin_drive (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Request and configuration
  input  wire logic pending,
  input  wire logic polarity,
  input  wire logic drive_select,
  // Pin
  output logic      pin_out,
  output logic      pin_oe_n
);

  typedef struct packed {
    logic out;
    logic oe_n;
  } sipc_pin_state_t;

  sipc_pin_state_t st_ff;
  sipc_pin_state_t nxt_st;

  // Level follows polarity; open drain only ever drives the asserted level.
  always_comb begin
    nxt_st.out  = polarity ? pending : ~pending; // R1 R3
    nxt_st.oe_n = drive_select & ~pending;       // R2 R4 R19
  end

  // Registering the pin keeps glitches from the OR tree off the board.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff.out  <= sipc_pkg::PIN_RST_OUT;
      st_ff.oe_n <= sipc_pkg::PIN_RST_OE_N;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out  = st_ff.out;
  assign pin_oe_n = st_ff.oe_n;

endmodule : sipc_pin_drive

`default_nettype wire

// *** hw/sipc_pkg.sv ***
`default_nettype none

// ==========================================================================
// Shared constants for the sensor interrupt pin controller.
// ==========================================================================
package sipc_pkg;

  // ========================================================================
  // Register addresses and values after reset.
  // ========================================================================
  localparam logic [7:0] ADDR_PIN_CFG   = 8'h28;
  localparam logic [7:0] ADDR_SRC_EN    = 8'h29;
  localparam logic [7:0] ADDR_ROUTE     = 8'h2a;
  localparam logic [7:0] RST_PIN_CFG    = 8'h00;
  localparam logic [7:0] RST_SRC_EN     = 8'h00;
  localparam logic [7:0] RST_ROUTE      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;

  // Writable bits of the pin configuration register; the rest are reserved.
  localparam logic [7:0] PIN_CFG_WR_MASK = 8'h33;
  localparam logic [7:0] PIN_CFG_RSVD    = 8'hcc;

  // ========================================================================
  // Field positions in the pin configuration register.
  // ========================================================================
  localparam int unsigned PIN_A_POL_BIT = 5;
  localparam int unsigned PIN_A_DRV_BIT = 4;
  localparam int unsigned PIN_B_POL_BIT = 1;
  localparam int unsigned PIN_B_DRV_BIT = 0;

  // ========================================================================
  // Source positions shared by the enable and routing registers.
  // ========================================================================
  localparam int unsigned NUM_SRC            = 8;
  localparam int unsigned SRC_DATA_READY     = 7;
  localparam int unsigned SRC_FIFO           = 6;
  localparam int unsigned SRC_PRESS_WINDOW   = 5;
  localparam int unsigned SRC_TEMP_WINDOW    = 4;
  localparam int unsigned SRC_PRESS_THRESH   = 3;
  localparam int unsigned SRC_TEMP_THRESH    = 2;
  localparam int unsigned SRC_PRESS_CHANGE   = 1;
  localparam int unsigned SRC_TEMP_CHANGE    = 0;

  // ========================================================================
  // Pin driver state after reset: push-pull, active low, idle high.
  // ========================================================================
  localparam logic PIN_RST_OUT  = 1'b1;
  localparam logic PIN_RST_OE_N = 1'b0;

endpackage : sipc_pkg

`default_nettype wire

// *** hw/sipc_route.sv ***
`default_nettype none

// ==========================================================================
// Source gating and routing onto the two interrupt pins.
// ==========================================================================
module sipc_route #(
  parameter int unsigned NUM_SRC = 8
) (
  // Event flags and configuration
  input  wire logic [NUM_SRC-1:0] evt_flags,
  input  wire logic [NUM_SRC-1:0] src_enable,
  input  wire logic [NUM_SRC-1:0] src_route,
  // Pending request per pin
  output logic                    pend_a,
  output logic                    pend_b
);

  logic [NUM_SRC-1:0] to_a;
  logic [NUM_SRC-1:0] to_b;

  // Each flag passes only when enabled and lands on exactly one pin.
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    assign to_a[i] = evt_flags[i] & src_enable[i] & src_route[i];  // R6 R7 R16
    assign to_b[i] = evt_flags[i] & src_enable[i] & ~src_route[i]; // R6 R7 R16
  end

  // All sources steered to a pin are merged with an OR.
  assign pend_a = |to_a; // R17
  assign pend_b = |to_b; // R17

endmodule : sipc_route

`default_nettype wire

// *** hw/sipc_top.sv ***
`default_nettype none

// Operation
// R1: Pin A is active low when its polarity bit is 0, else active high.
// R2: Pin A is push-pull when its drive bit is 0, else open drain.
// R3: Pin B is active low when its polarity bit is 0, else active high.
// R4: Pin B is push-pull when its drive bit is 0, else open drain.
// R5: Reserved configuration bits read zero and ignore writes.
// R6: An event flag reaches a pin only while its enable bit is set.
// R7: Each enabled source drives exactly one pin, chosen by its routing bit.
// R8: Enable bit 7 gates data ready; resets to disabled.
// R9: Enable bit 6 gates the FIFO event; resets to disabled.
// R10: Enable bit 5 gates pressure window; resets to disabled.
// R11: Enable bit 4 gates temperature window; resets to disabled.
// R12: Enable bit 3 gates pressure threshold; resets to disabled.
// R13: Enable bit 2 gates temperature threshold; resets to disabled.
// R14: Enable bit 1 gates pressure change; resets to disabled.
// R15: Enable bit 0 gates temperature change; resets to disabled.
// R16: Routing bit 0 sends a source to pin B, 1 sends it to pin A.
// R17: All enabled sources routed to a pin are ORed together.
// R18: The host reads the source register to find which blocks fired.
// R19: Open drain drives only the asserted level, releases when idle.

// ==========================================================================
// Interrupt pin controller top level.
// ==========================================================================
module sipc_top #(
  parameter int unsigned NUM_SRC = 8
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // Register access from the serial bus slave
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr_en,
  input  wire logic [7:0]         reg_wr_data,
  input  wire logic               reg_rd_en,
  output logic [7:0]              reg_rd_data,
  output logic                    reg_rd_valid,
  // Event flags from the functional blocks
  input  wire logic [NUM_SRC-1:0] evt_flags,
  // Interrupt pin A
  output logic                    irq_pin_a_out,
  output logic                    irq_pin_a_oe_n,
  // Interrupt pin B
  output logic                    irq_pin_b_out,
  output logic                    irq_pin_b_oe_n
);

  // ========================================================================
  // State.
  // ========================================================================
  typedef struct packed {
    logic [7:0]         pin_cfg;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] route;
    logic [7:0]         rd_data;
    logic               rd_valid;
  } sipc_state_t;

  sipc_state_t st_ff;
  sipc_state_t nxt_st;

  logic pend_a;
  logic pend_b;
  logic pin_a_pol;
  logic pin_a_drive_select;
  logic pin_b_pol;
  logic pin_b_drive_select;

  // ========================================================================
  // Register writes and reads.
  // ========================================================================

  // Writes land in the addressed register; reads are answered one cycle on.
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.rd_valid = reg_rd_en;
    if (reg_wr_en) begin
      case (reg_addr)
        sipc_pkg::ADDR_PIN_CFG: begin
          // Reserved bits are masked so they can never be set.
          nxt_st.pin_cfg = reg_wr_data & sipc_pkg::PIN_CFG_WR_MASK; // R5
        end
        sipc_pkg::ADDR_SRC_EN: begin
          nxt_st.src_en = reg_wr_data[NUM_SRC-1:0]; // R8 R9 R10 R11 R12 R13 R14 R15
        end
        sipc_pkg::ADDR_ROUTE: begin
          nxt_st.route = reg_wr_data[NUM_SRC-1:0]; // R16
        end
        default: begin
          nxt_st.route = st_ff.route;
        end
      endcase
    end
    if (reg_rd_en) begin
      case (reg_addr)
        sipc_pkg::ADDR_PIN_CFG: begin
          nxt_st.rd_data = st_ff.pin_cfg; // R5
        end
        sipc_pkg::ADDR_SRC_EN: begin
          nxt_st.rd_data = st_ff.src_en;
        end
        sipc_pkg::ADDR_ROUTE: begin
          nxt_st.rd_data = st_ff.route;
        end
        default: begin
          nxt_st.rd_data = sipc_pkg::RD_UNMAPPED;
        end
      endcase
    end
  end

  // All interrupts start disabled, routed to pin B, push-pull, active low.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff.pin_cfg  <= sipc_pkg::RST_PIN_CFG;
      st_ff.src_en   <= sipc_pkg::RST_SRC_EN;  // R8 R9 R10 R11 R12 R13 R14 R15
      st_ff.route    <= sipc_pkg::RST_ROUTE;   // R16
      st_ff.rd_data  <= sipc_pkg::RD_UNMAPPED;
      st_ff.rd_valid <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rd_data  = st_ff.rd_data;
  assign reg_rd_valid = st_ff.rd_valid;

  // Configuration fields for each pin.
  assign pin_a_pol          = st_ff.pin_cfg[sipc_pkg::PIN_A_POL_BIT];
  assign pin_a_drive_select = st_ff.pin_cfg[sipc_pkg::PIN_A_DRV_BIT];
  assign pin_b_pol          = st_ff.pin_cfg[sipc_pkg::PIN_B_POL_BIT];
  assign pin_b_drive_select = st_ff.pin_cfg[sipc_pkg::PIN_B_DRV_BIT];

  // ========================================================================
  // Routing and pin drivers.
  // ========================================================================

  // The host still has to read the source register to tell sources apart.
  sipc_route #(
    .NUM_SRC (NUM_SRC)
  ) u_route (
    .evt_flags  (evt_flags),
    .src_enable (st_ff.src_en),
    .src_route  (st_ff.route),
    .pend_a     (pend_a),
    .pend_b     (pend_b)
  );

  // Pin A driver.
  sipc_pin_drive u_pin_a (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .pending      (pend_a),
    .polarity     (pin_a_pol),
    .drive_select (pin_a_drive_select),
    .pin_out      (irq_pin_a_out),
    .pin_oe_n     (irq_pin_a_oe_n)
  );

  // Pin B driver.
  sipc_pin_drive u_pin_b (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .pending      (pend_b),
    .polarity     (pin_b_pol),
    .drive_select (pin_b_drive_select),
    .pin_out      (irq_pin_b_out),
    .pin_oe_n     (irq_pin_b_oe_n)
  );

  // ========================================================================
  // Checks.
  // ========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic [NUM_SRC-1:0] live;
  assign live = evt_flags & st_ff.src_en;

  // A driven pin A shows the pending state in the configured polarity.
  a_pin_a_level: assert property ( // R1
    !irq_pin_a_oe_n |->
      irq_pin_a_out == ($past(pin_a_pol) ? $past(pend_a) : !$past(pend_a)))
    else $error("pin A level does not match polarity");

  // Push-pull pin A is always driven.
  a_pin_a_pushpull: assert property ( // R2
    !$past(pin_a_drive_select) |-> !irq_pin_a_oe_n)
    else $error("pin A released in push-pull mode");

  // A driven pin B shows the pending state in the configured polarity.
  a_pin_b_level: assert property ( // R3
    !irq_pin_b_oe_n |->
      irq_pin_b_out == ($past(pin_b_pol) ? $past(pend_b) : !$past(pend_b)))
    else $error("pin B level does not match polarity");

  // Push-pull pin B is always driven.
  a_pin_b_pushpull: assert property ( // R4
    !$past(pin_b_drive_select) |-> !irq_pin_b_oe_n)
    else $error("pin B released in push-pull mode");

  // Reserved bits stay zero whatever is written.
  a_rsvd_zero: assert property ( // R5
    reg_wr_en && reg_addr == sipc_pkg::ADDR_PIN_CFG |=>
      (st_ff.pin_cfg & sipc_pkg::PIN_CFG_RSVD) == 8'h00)
    else $error("reserved configuration bit was set");

  // Reading the configuration register returns zero in reserved bits.
  a_rsvd_read: assert property ( // R5
    reg_rd_en && reg_addr == sipc_pkg::ADDR_PIN_CFG |=>
      reg_rd_valid && (reg_rd_data & sipc_pkg::PIN_CFG_RSVD) == 8'h00)
    else $error("reserved configuration bit read nonzero");

  // No pin becomes pending without an enabled flag behind it.
  a_gate_needed: assert property ( // R6
    (pend_a || pend_b) |-> live != '0)
    else $error("pin pending with no enabled flag");

  // An enabled FIFO flag drives the pin its routing bit selects, on the next edge.
  a_route_one: assert property ( // R7
    live[sipc_pkg::SRC_FIFO] |=>
      ($past(st_ff.route[sipc_pkg::SRC_FIFO]) ?
        (!irq_pin_a_oe_n && irq_pin_a_out == $past(pin_a_pol)) :
        (!irq_pin_b_oe_n && irq_pin_b_out == $past(pin_b_pol))))
    else $error("FIFO event missed its routed pin");

  // Each enable bit gates its own source.
  a_en_ready: assert property ( // R8
    evt_flags[sipc_pkg::SRC_DATA_READY] && st_ff.src_en[sipc_pkg::SRC_DATA_READY]
      |-> pend_a || pend_b)
    else $error("data ready not passed");

  a_en_fifo: assert property ( // R9
    (live == '0) && evt_flags[sipc_pkg::SRC_FIFO] |-> !pend_a && !pend_b)
    else $error("disabled FIFO event reached a pin");

  a_en_pwin: assert property ( // R10
    evt_flags[sipc_pkg::SRC_PRESS_WINDOW] && st_ff.src_en[sipc_pkg::SRC_PRESS_WINDOW]
      |-> pend_a || pend_b)
    else $error("pressure window not passed");

  a_en_twin: assert property ( // R11
    evt_flags[sipc_pkg::SRC_TEMP_WINDOW] && st_ff.src_en[sipc_pkg::SRC_TEMP_WINDOW]
      |-> pend_a || pend_b)
    else $error("temperature window not passed");

  a_en_pth: assert property ( // R12
    evt_flags[sipc_pkg::SRC_PRESS_THRESH] && st_ff.src_en[sipc_pkg::SRC_PRESS_THRESH]
      |-> pend_a || pend_b)
    else $error("pressure threshold not passed");

  a_en_tth: assert property ( // R13
    evt_flags[sipc_pkg::SRC_TEMP_THRESH] && st_ff.src_en[sipc_pkg::SRC_TEMP_THRESH]
      |-> pend_a || pend_b)
    else $error("temperature threshold not passed");

  a_en_pchg: assert property ( // R14
    evt_flags[sipc_pkg::SRC_PRESS_CHANGE] && st_ff.src_en[sipc_pkg::SRC_PRESS_CHANGE]
      |-> pend_a || pend_b)
    else $error("pressure change not passed");

  a_en_tchg: assert property ( // R15
    evt_flags[sipc_pkg::SRC_TEMP_CHANGE] && st_ff.src_en[sipc_pkg::SRC_TEMP_CHANGE]
      |-> pend_a || pend_b)
    else $error("temperature change not passed");

  // An enable write takes effect on the next edge.
  a_en_write: assert property ( // R8
    reg_wr_en && reg_addr == sipc_pkg::ADDR_SRC_EN |=>
      st_ff.src_en == $past(reg_wr_data))
    else $error("enable register did not update");

  // With every routing bit clear, all traffic goes to pin B.
  a_route_zero: assert property ( // R16
    st_ff.route == '0 && live != '0 |-> pend_b && !pend_a)
    else $error("routing bit 0 did not select pin B");

  // With every routing bit set, all traffic goes to pin A.
  a_route_ones: assert property ( // R16
    st_ff.route == '1 && live != '0 |-> pend_a && !pend_b)
    else $error("routing bit 1 did not select pin A");

  // Pin requests equal the OR of their routed sources.
  a_or_merge: assert property ( // R17
    pend_a == |(live & st_ff.route) && pend_b == |(live & ~st_ff.route))
    else $error("pin request is not the OR of its sources");

  // Open drain pin A is released exactly when nothing was pending.
  a_od_release_a: assert property ( // R19
    $past(pin_a_drive_select) |-> irq_pin_a_oe_n == !$past(pend_a))
    else $error("open drain pin A drive wrong");

  // Open drain pin B is released exactly when nothing was pending.
  a_od_release_b: assert property ( // R19
    $past(pin_b_drive_select) |-> irq_pin_b_oe_n == !$past(pend_b))
    else $error("open drain pin B drive wrong");

  // The enable register changes only when it is written.
  a_en_hold: assert property ( // R8
    !(reg_wr_en && reg_addr == sipc_pkg::ADDR_SRC_EN) |=> $stable(st_ff.src_en))
    else $error("enable register changed without a write");

  // The routing register changes only when it is written.
  a_route_hold: assert property ( // R16
    !(reg_wr_en && reg_addr == sipc_pkg::ADDR_ROUTE) |=> $stable(st_ff.route))
    else $error("routing register changed without a write");

  // The pin configuration changes only when it is written.
  a_cfg_hold: assert property ( // R2
    !(reg_wr_en && reg_addr == sipc_pkg::ADDR_PIN_CFG) |=> $stable(st_ff.pin_cfg))
    else $error("pin configuration changed without a write");

  // A routing write takes effect on the next edge.
  a_route_write: assert property ( // R16
    reg_wr_en && reg_addr == sipc_pkg::ADDR_ROUTE |=>
      st_ff.route == $past(reg_wr_data))
    else $error("routing register did not update");

  // A driven open drain pin A can only show its asserted level.
  a_od_level_a: assert property ( // R19
    $past(pin_a_drive_select) && !irq_pin_a_oe_n |->
      irq_pin_a_out == $past(pin_a_pol))
    else $error("open drain pin A drove the idle level");

  // A driven open drain pin B can only show its asserted level.
  a_od_level_b: assert property ( // R19
    $past(pin_b_drive_select) && !irq_pin_b_oe_n |->
      irq_pin_b_out == $past(pin_b_pol))
    else $error("open drain pin B drove the idle level");

  // Data ready with a clear routing bit asserts pin B on the next edge.
  a_ready_to_b: assert property ( // R16
    live[sipc_pkg::SRC_DATA_READY] && !st_ff.route[sipc_pkg::SRC_DATA_READY] |=>
      !irq_pin_b_oe_n && irq_pin_b_out == $past(pin_b_pol))
    else $error("data ready did not assert pin B");

  // Pressure change with a set routing bit asserts pin A on the next edge.
  a_pchg_to_a: assert property ( // R7
    live[sipc_pkg::SRC_PRESS_CHANGE] && st_ff.route[sipc_pkg::SRC_PRESS_CHANGE] |=>
      !irq_pin_a_oe_n && irq_pin_a_out == $past(pin_a_pol))
    else $error("pressure change did not assert pin A");

endmodule : sipc_top

`default_nettype wire

// *** verification/sipc_host_model.sv ***
`default_nettype none

// ==========================================================================
// Host side of one interrupt line: board pull resistor and level detect.
// ==========================================================================
module sipc_host_model (
  // Pin from the device
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // Board wiring: the pull resistor holds the line at its idle level
  input  wire logic active_high,
  // Resolved line and detected request
  output logic      line_level,
  output logic      irq_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released line goes to the pull level, never to the last driven value.
  assign line_level = pin_oe_n ? ~active_high : pin_out;
  // On the active level the host would go on to read the source register.
  assign irq_seen = (line_level == active_high);
endmodule : sipc_host_model

`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none

// ==========================================================================
// Self-checking bench for the interrupt pin controller.
// ==========================================================================
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] route;
    logic [7:0] cfg;
    logic [7:0] flags;
    logic       pa;
    logic       pb;
  } sipc_row_t;

  // Each row: enable, routing, pin config, flags, pin A pending, pin B pending.
  localparam sipc_row_t ROWS [0:13] = '{
    '{8'h80, 8'h00, 8'h00, 8'h80, 1'b0, 1'b1}, '{8'h40, 8'h40, 8'h00, 8'h40, 1'b1, 1'b0},
    '{8'h20, 8'h00, 8'h02, 8'h20, 1'b0, 1'b1}, '{8'h10, 8'h10, 8'h20, 8'h10, 1'b1, 1'b0},
    '{8'h08, 8'h00, 8'h01, 8'h08, 1'b0, 1'b1}, '{8'h04, 8'h04, 8'h10, 8'h04, 1'b1, 1'b0},
    '{8'h02, 8'h00, 8'h03, 8'h02, 1'b0, 1'b1}, '{8'h01, 8'h01, 8'h30, 8'h01, 1'b1, 1'b0},
    '{8'hff, 8'h0f, 8'h33, 8'h00, 1'b0, 1'b0}, '{8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 1'b0},
    '{8'h7f, 8'hff, 8'h00, 8'h80, 1'b0, 1'b0}, '{8'hff, 8'hf0, 8'h00, 8'hc3, 1'b1, 1'b1},
    '{8'hff, 8'haa, 8'h22, 8'hff, 1'b1, 1'b1}, '{8'hfe, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0}
  };

  logic       sys_clk;
  logic       rstn;
  logic [7:0] reg_addr;
  logic       reg_wr_en;
  logic [7:0] reg_wr_data;
  logic       reg_rd_en;
  logic [7:0] reg_rd_data;
  logic       reg_rd_valid;
  logic [7:0] evt_flags;
  logic       a_out;
  logic       a_oe_n;
  logic       b_out;
  logic       b_oe_n;
  logic [7:0] cur_cfg;
  logic       a_line;
  logic       a_seen;
  logic       b_line;
  logic       b_seen;
  logic [7:0] rd;
  int         n_errors;
  int         n_tests;
  int         cycles;

  // ========================================================================
  // Design, host models and clock.
  // ========================================================================
  sipc_top dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .evt_flags(evt_flags), .irq_pin_a_out(a_out),
    .irq_pin_a_oe_n(a_oe_n), .irq_pin_b_out(b_out), .irq_pin_b_oe_n(b_oe_n));
  sipc_host_model host_a (.pin_out(a_out), .pin_oe_n(a_oe_n),
    .active_high(cur_cfg[sipc_pkg::PIN_A_POL_BIT]), .line_level(a_line), .irq_seen(a_seen));
  sipc_host_model host_b (.pin_out(b_out), .pin_oe_n(b_oe_n),
    .active_high(cur_cfg[sipc_pkg::PIN_B_POL_BIT]), .line_level(b_line), .irq_seen(b_seen));

  // A 20 ns period; the timeout cuts a hang well after the sequence ends.
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  // ========================================================================
  // Shared tasks.
  // ========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Open drain releases when idle, so the level is only compared while driven.
  task automatic chk_pin(input logic out, oe_n, seen, pend, pol, od);
    chk({7'h00, oe_n}, {7'h00, od & ~pend});
    if (!(od & ~pend)) chk({7'h00, out}, {7'h00, pend ? pol : ~pol});
    chk({7'h00, seen}, {7'h00, pend});
  endtask : chk_pin

  // The extra idle cycle keeps a strobe from being lowered and raised at once.
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    reg_addr    = addr;
    reg_wr_data = data;
    reg_wr_en   = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    @(negedge sys_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    reg_addr  = addr;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    chk({7'h00, reg_rd_valid}, 8'h01);
    data = reg_rd_data;
    @(negedge sys_clk);
    chk({7'h00, reg_rd_valid}, 8'h00);
  endtask : reg_read

  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ========================================================================
  // Main sequence.
  // ========================================================================
  initial begin
    rstn        = 1'b0;
    reg_addr    = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
    evt_flags   = 8'hff;
    cur_cfg     = 8'h00;
    n_errors    = 0;
    n_tests     = 0;
    cycles      = 0;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    // Everything disabled after reset: all flags high, both pins idle low-active.
    chk_pin(a_out, a_oe_n, a_seen, 1'b0, 1'b0, 1'b0);
    chk_pin(b_out, b_oe_n, b_seen, 1'b0, 1'b0, 1'b0);
    reg_read(sipc_pkg::ADDR_PIN_CFG, rd);
    chk(rd, sipc_pkg::RST_PIN_CFG);
    reg_read(sipc_pkg::ADDR_SRC_EN, rd);
    chk(rd, sipc_pkg::RST_SRC_EN);
    reg_read(sipc_pkg::ADDR_ROUTE, rd);
    chk(rd, sipc_pkg::RST_ROUTE);
    reg_read(8'h2b, rd);
    chk(rd, sipc_pkg::RD_UNMAPPED);

    // Table of ordinary cases.
    foreach (ROWS[i]) begin
      evt_flags = 8'h00;
      reg_write(sipc_pkg::ADDR_SRC_EN, ROWS[i].en);
      reg_write(sipc_pkg::ADDR_ROUTE, ROWS[i].route);
      reg_write(sipc_pkg::ADDR_PIN_CFG, ROWS[i].cfg);
      cur_cfg   = ROWS[i].cfg;
      evt_flags = ROWS[i].flags;
      @(negedge sys_clk);
      chk_pin(a_out, a_oe_n, a_seen, ROWS[i].pa, cur_cfg[5], cur_cfg[4]);
      chk_pin(b_out, b_oe_n, b_seen, ROWS[i].pb, cur_cfg[1], cur_cfg[0]);
      reg_read(sipc_pkg::ADDR_ROUTE, rd);
      chk(rd, ROWS[i].route);
    end

    // Reserved configuration bits ignore writes and read zero.
    reg_write(sipc_pkg::ADDR_PIN_CFG, 8'hff);
    reg_read(sipc_pkg::ADDR_PIN_CFG, rd);
    chk(rd, 8'h33);
    reg_write(sipc_pkg::ADDR_PIN_CFG, 8'hcc);
    reg_read(sipc_pkg::ADDR_PIN_CFG, rd);
    chk(rd, 8'h00);
    cur_cfg = 8'h00;

    // Disabling a source while its flag stays high must drop the pin.
    reg_write(sipc_pkg::ADDR_SRC_EN, 8'hff);
    reg_write(sipc_pkg::ADDR_ROUTE, 8'h00);
    evt_flags = 8'h01;
    @(negedge sys_clk);
    chk_pin(b_out, b_oe_n, b_seen, 1'b1, 1'b0, 1'b0);
    reg_write(sipc_pkg::ADDR_SRC_EN, 8'hfe);
    chk_pin(b_out, b_oe_n, b_seen, 1'b0, 1'b0, 1'b0);

    // A second reset in mid-run returns pins and registers to defaults.
    reg_write(sipc_pkg::ADDR_PIN_CFG, 8'h33);
    reg_write(sipc_pkg::ADDR_SRC_EN, 8'hff);
    evt_flags = 8'hff;
    rstn      = 1'b0;
    #1;
    chk({6'h00, a_out, a_oe_n}, {6'h00, sipc_pkg::PIN_RST_OUT, sipc_pkg::PIN_RST_OE_N});
    chk({6'h00, b_out, b_oe_n}, {6'h00, sipc_pkg::PIN_RST_OUT, sipc_pkg::PIN_RST_OE_N});
    @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    // All flags stay high, yet nothing is enabled any more, so both pins idle.
    chk_pin(a_out, a_oe_n, a_seen, 1'b0, 1'b0, 1'b0);
    chk_pin(b_out, b_oe_n, b_seen, 1'b0, 1'b0, 1'b0);
    reg_read(sipc_pkg::ADDR_SRC_EN, rd);
    chk(rd, 8'h00);
    reg_read(sipc_pkg::ADDR_PIN_CFG, rd);
    chk(rd, sipc_pkg::RST_PIN_CFG);
    finish_test();
  end
endmodule : tb

`default_nettype wire
